// ==== design/jlbu_core.sv ====
`timescale 1ns/10ps
// How it works
// - Opcode 010111 is the jump; write-result bit selects plain or linking form.
// - Target is the 9-bit source field if immediate, else low bits of that register.
// - An executed jump loads the program counter with the resolved target.
// - Every jump takes 4 cycles; zero flag set only when result equals zero.
// - Linking writes return address into bits 8:0, bits 31:9 stay unchanged.
// - Destination field picks the register that receives the return address.
// - Plain encoding with write-result bit set acts exactly as the linking form.
// - Write-result bit clear: destination ignored, no register written.
// - Carry flag set unless incremented program counter is zero.
// - No return stack; return addresses live only in ordinary RAM registers.
// - Jump executes only if the 4-bit condition matches flags; 1111 always.
// - False condition: 4-cycle no-op, no flag, register or jump change.
module jlbu_core (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Run control, same clock domain
  input wire logic run,
  // Core RAM load and inspect port
  input wire logic ldWr,
  input wire logic ldRd,
  input wire logic [8:0] ldAddr,
  input wire logic [31:0] ldWrData,
  output logic [31:0] ldRdData,
  // Core state
  output logic [8:0] pcOut,
  output logic zeroFlag,
  output logic carryFlag,
  // Event pulses
  output logic instrDone,
  output logic jumpTaken,
  output logic linkWrite
);

  logic [31:0] coreRam [jlbu_pkg::RAM_DEPTH];
  jlbu_pkg::jlbu_state_t stFf;
  logic [8:0] pcFf;
  logic zFf;
  logic cFf;
  logic [31:0] instrFf;
  logic [31:0] srcValFf;
  logic [31:0] dstValFf;
  logic [31:0] rdDataFf;
  logic doneFf;
  logic takenFf;
  logic linkFf;

  logic isJump;
  logic zBit;
  logic cBit;
  logic rBit;
  logic iBit;
  logic [3:0] condField;
  logic [8:0] dstIdx;
  logic [8:0] srcIdx;
  logic condMet;
  logic [8:0] target;
  logic [8:0] retAddr;
  logic execJump;
  logic execSkip;
  logic inExec;

  assign isJump = instrFf[jlbu_pkg::OPC_HI:jlbu_pkg::OPC_LO] == jlbu_pkg::OPC_JUMP;
  assign zBit = instrFf[jlbu_pkg::ZBIT_POS];
  assign cBit = instrFf[jlbu_pkg::CBIT_POS];
  assign rBit = instrFf[jlbu_pkg::RBIT_POS];
  assign iBit = instrFf[jlbu_pkg::IBIT_POS];
  assign condField = instrFf[jlbu_pkg::CON_HI:jlbu_pkg::CON_LO];
  assign dstIdx = instrFf[jlbu_pkg::DST_HI:jlbu_pkg::DST_LO];
  assign srcIdx = instrFf[jlbu_pkg::SRC_HI:jlbu_pkg::SRC_LO];

  // Each code bit enables one {C,Z} combination, so 1111 always runs
  assign condMet = condField[{cFf, zFf}];
  assign target = iBit ? srcIdx : srcValFf[8:0];
  // 9-bit add drops the carry, giving the wrap at the top address
  assign retAddr = pcFf + jlbu_pkg::PC_ONE;

  assign inExec = stFf == jlbu_pkg::JLBU_EXEC;
  assign execJump = inExec && isJump && condMet;
  assign execSkip = inExec && isJump && !condMet;

  // Sequencer: every instruction spends four states, fetch to exec
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      stFf <= jlbu_pkg::JLBU_IDLE;
    end else begin
      case (stFf)
        jlbu_pkg::JLBU_IDLE: begin
          if (run) begin
            stFf <= jlbu_pkg::JLBU_FETCH;
          end
        end
        jlbu_pkg::JLBU_FETCH: stFf <= jlbu_pkg::JLBU_DECODE;
        jlbu_pkg::JLBU_DECODE: stFf <= jlbu_pkg::JLBU_OPREAD;
        jlbu_pkg::JLBU_OPREAD: stFf <= jlbu_pkg::JLBU_EXEC;
        jlbu_pkg::JLBU_EXEC: begin
          stFf <= run ? jlbu_pkg::JLBU_FETCH : jlbu_pkg::JLBU_IDLE;
        end
        default: stFf <= jlbu_pkg::JLBU_IDLE;
      endcase
    end
  end

  // Instruction capture
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      instrFf <= jlbu_pkg::WORD_RESET;
    end else if (stFf == jlbu_pkg::JLBU_FETCH) begin
      instrFf <= coreRam[pcFf];
    end
  end

  // Operand capture; a load write after decode is not seen by this instruction
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      srcValFf <= jlbu_pkg::WORD_RESET;
      dstValFf <= jlbu_pkg::WORD_RESET;
    end else if (stFf == jlbu_pkg::JLBU_DECODE) begin
      srcValFf <= coreRam[srcIdx];
      dstValFf <= coreRam[dstIdx];
    end
  end

  // Program counter
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pcFf <= jlbu_pkg::PC_RESET;
    end else if (inExec) begin
      if (execJump) begin
        pcFf <= target;
      end else begin
        pcFf <= retAddr;
      end
    end
  end

  // Zero flag; a skipped jump leaves it alone
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      zFf <= jlbu_pkg::FLAG_RESET;
    end else if (execJump && zBit) begin
      zFf <= retAddr == jlbu_pkg::ADDR_ZERO;
    end
  end

  // Carry flag; clear only for a jump from the top address
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cFf <= jlbu_pkg::FLAG_RESET;
    end else if (execJump && cBit) begin
      cFf <= retAddr != jlbu_pkg::ADDR_ZERO;
    end
  end

  // Core RAM: link write and load port share one process.
  // Link write wins on a clash; load writes in that cycle are lost.
  always_ff @(posedge mclk) begin
    if (execJump && rBit) begin
      coreRam[dstIdx] <= {dstValFf[31:9], retAddr};
    end else if (ldWr) begin
      coreRam[ldAddr] <= ldWrData;
    end
  end

  // Inspect read, data one cycle after the strobe
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdDataFf <= jlbu_pkg::WORD_RESET;
    end else if (ldRd) begin
      rdDataFf <= coreRam[ldAddr];
    end
  end

  // Completion pulse
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      doneFf <= 1'b0;
    end else begin
      doneFf <= inExec;
    end
  end

  // Taken pulse, program counter already loaded when it shows
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      takenFf <= 1'b0;
    end else begin
      takenFf <= execJump;
    end
  end

  // Link pulse
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      linkFf <= 1'b0;
    end else begin
      linkFf <= execJump && rBit;
    end
  end

  // Cycles since the last completion, saturating
  logic [2:0] gapFf;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      gapFf <= 3'h0;
    end else if (instrDone) begin
      gapFf <= 3'h1;
    end else if (gapFf != 3'h0 && gapFf != 3'h7) begin
      gapFf <= gapFf + 3'h1;
    end
  end

  assign pcOut = pcFf;
  assign zeroFlag = zFf;
  assign carryFlag = cFf;
  assign ldRdData = rdDataFf;
  assign instrDone = doneFf;
  assign jumpTaken = takenFf;
  assign linkWrite = linkFf;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  chk_four_cycles: assert property (
    stFf == jlbu_pkg::JLBU_FETCH |-> ##3 stFf == jlbu_pkg::JLBU_EXEC ##1 instrDone
  ) else $error("instruction did not take four cycles");

  chk_pc_loads: assert property (
    execJump |=> pcFf == $past(target) && jumpTaken
  ) else $error("taken jump did not load the target");

  chk_imm_target: assert property (
    execJump && iBit |=> pcFf == $past(instrFf[8:0])
  ) else $error("immediate jump went to wrong address");

  chk_link_word: assert property (
    execJump && rBit |=>
      coreRam[$past(dstIdx)] == {$past(dstValFf[31:9]), $past(retAddr)} && linkWrite
  ) else $error("link word wrong or upper bits disturbed");

  chk_no_link: assert property (
    inExec && isJump && !rBit |=> !linkWrite
  ) else $error("link write without write-result bit");

  chk_skip_nop: assert property (
    execSkip |=> pcFf == $past(retAddr) && $stable(zFf) && $stable(cFf) && !linkWrite
  ) else $error("skipped jump changed state");

  chk_carry_flag: assert property (
    execJump && cBit |=> cFf == ($past(pcFf) != jlbu_pkg::PC_TOP)
  ) else $error("carry result wrong");

  chk_zero_flag: assert property (
    execJump && zBit |=> zFf == ($past(pcFf) == jlbu_pkg::PC_TOP)
  ) else $error("zero result wrong");

  chk_pc_wrap: assert property (
    inExec && !execJump && pcFf == jlbu_pkg::PC_TOP |=> pcFf == jlbu_pkg::ADDR_ZERO
  ) else $error("program counter did not wrap");

  chk_always_cond: assert property (
    inExec && isJump && condField == jlbu_pkg::COND_ALWAYS |-> execJump
  ) else $error("unconditional jump not taken");

  chk_decode_gate: assert property (
    inExec && !isJump |-> !execJump && !execSkip
  ) else $error("non-jump opcode treated as a jump");

  chk_reg_target: assert property (
    execJump && !iBit |=> pcFf == $past(srcValFf[8:0])
  ) else $error("register jump went to wrong address");

  chk_link_dest: assert property (
    execJump && rBit |=> coreRam[$past(dstIdx)][8:0] == $past(pcFf) + jlbu_pkg::PC_ONE
  ) else $error("return address not in selected register");

  chk_plain_keeps: assert property (
    execJump && !rBit && !ldWr |=> coreRam[$past(dstIdx)] == $past(coreRam[dstIdx])
  ) else $error("plain jump wrote a register");

  chk_state_holds: assert property (
    !inExec |=> $stable(zFf) && $stable(cFf) && $stable(pcFf)
  ) else $error("state changed outside execute");

  chk_done_pulse: assert property (
    instrDone |=> !instrDone
  ) else $error("completion pulse too long");

  chk_done_gap: assert property (
    instrDone && gapFf != 3'h0 |-> gapFf >= 3'h4
  ) else $error("completions closer than four cycles");

  chk_taken_done: assert property (
    jumpTaken |-> instrDone
  ) else $error("taken pulse without completion");

  chk_never_cond: assert property (
    inExec && isJump && condField == 4'h0 |-> execSkip
  ) else $error("never condition executed");

  chk_flags_excl: assert property (
    execJump && zBit && cBit |=> zFf != cFf
  ) else $error("zero and carry both set or both clear");

  chk_load_write: assert property (
    ldWr && !(execJump && rBit) |=> coreRam[$past(ldAddr)] == $past(ldWrData)
  ) else $error("load write did not land");

  chk_read_data: assert property (
    ldRd |=> ldRdData == $past(coreRam[ldAddr])
  ) else $error("inspect read returned wrong word");

  chk_run_stop: assert property (
    inExec && !run |=> stFf == jlbu_pkg::JLBU_IDLE
  ) else $error("sequencer did not stop");

  chk_state_onehot: assert property (
    $onehot(stFf)
  ) else $error("sequencer state not one-hot");

  chk_instruction_code_field_capture: assert property (
    stFf == jlbu_pkg::JLBU_FETCH |=> instrFf == $past(coreRam[pcFf])
  ) else $error("instruction word not captured");

  cov_cond_taken: cover property (execJump && condField != jlbu_pkg::COND_ALWAYS);
  cov_plain_jump: cover property (execJump && !rBit);
  cov_link_jump: cover property (execJump && rBit);
  cov_skipped: cover property (execSkip);
  cov_top_link: cover property (execJump && rBit && pcFf == jlbu_pkg::PC_TOP);

endmodule : jlbu_core

// ==== design/jlbu_pkg.sv ====
package jlbu_pkg;
  localparam int PC_W = 9;
  localparam int DATA_W = 32;
  localparam int RAM_DEPTH = 512;
  localparam int INSTRUCTION_CODE_FIELD_CYCLES = 4;
  // Instruction word fields
  localparam int OPC_HI = 31;
  localparam int OPC_LO = 26;
  localparam int ZBIT_POS = 25;
  localparam int CBIT_POS = 24;
  localparam int RBIT_POS = 23;
  localparam int IBIT_POS = 22;
  localparam int CON_HI = 21;
  localparam int CON_LO = 18;
  localparam int DST_HI = 17;
  localparam int DST_LO = 9;
  localparam int SRC_HI = 8;
  localparam int SRC_LO = 0;
  localparam logic [5:0] OPC_JUMP = 6'h17;
  localparam logic [3:0] COND_ALWAYS = 4'hF;
  localparam logic [8:0] PC_RESET = 9'h000;
  localparam logic [8:0] PC_ONE = 9'h001;
  localparam logic [8:0] PC_TOP = 9'h1FF;
  localparam logic [8:0] ADDR_ZERO = 9'h000;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  typedef enum logic [4:0] {
    JLBU_IDLE = 5'h01,
    JLBU_FETCH = 5'h02,
    JLBU_DECODE = 5'h04,
    JLBU_OPREAD = 5'h08,
    JLBU_EXEC = 5'h10
  } jlbu_state_t;
endpackage : jlbu_pkg

// ==== dv/jlbu_core_tb.sv ====
`timescale 1ns/10ps
module jlbu_core_tb;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic run = 1'b0;
  logic ldWr = 1'b0;
  logic ldRd = 1'b0;
  logic [8:0] ldAddr = 9'h000;
  logic [31:0] ldWrData = 32'h0000_0000;
  logic [31:0] ldRdData;
  logic [8:0] pcOut;
  logic zeroFlag;
  logic carryFlag;
  logic instrDone;
  logic jumpTaken;
  logic linkWrite;
  int errCount = 0;
  int numChecks = 0;

  jlbu_core uut (.mclk(mclk), .rst_b(rst_b), .run(run), .ldWr(ldWr), .ldRd(ldRd),
    .ldAddr(ldAddr), .ldWrData(ldWrData), .ldRdData(ldRdData), .pcOut(pcOut),
    .zeroFlag(zeroFlag), .carryFlag(carryFlag), .instrDone(instrDone),
    .jumpTaken(jumpTaken), .linkWrite(linkWrite));

  always #25 mclk = ~mclk;

  function automatic logic [31:0] mk(logic [3:0] effect_and_immediate_bits, logic [3:0] cond, logic [8:0] dst,
    logic [8:0] src);
    return {jlbu_pkg::OPC_JUMP, effect_and_immediate_bits, cond, dst, src};
  endfunction : mk

  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      errCount++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(logic [8:0] a, logic [31:0] d);
    @(posedge mclk);
    ldWr <= 1'b1;
    ldAddr <= a;
    ldWrData <= d;
  endtask : wr

  task automatic rd(logic [8:0] a, logic [31:0] exp);
    @(posedge mclk);
    ldRd <= 1'b1;
    ldAddr <= a;
    @(posedge mclk);
    ldRd <= 1'b0;
    #1;
    chk(32'(pcOut), 32'h0000_0041);
    chk(ldRdData, exp);
  endtask : rd

  // Waits for the next completion pulse; cyc of 0 skips the spacing check
  task automatic step(int cyc, logic [8:0] pc, logic [1:0] zc, logic [1:0] jl);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (instrDone !== 1'b1 && n < 20);
    chk(32'(instrDone), 32'h0000_0001);
    if (cyc > 0) chk(32'(n), 32'(cyc));
    chk(32'(pcOut), 32'(pc));
    chk(32'({zeroFlag, carryFlag}), 32'(zc));
    chk(32'({jumpTaken, linkWrite}), 32'(jl));
  endtask : step

  task automatic t_load;
    wr(9'h000, mk(4'hF, 4'hF, 9'h020, 9'h010));
    wr(9'h010, mk(4'hF, 4'h0, 9'h021, 9'h055));
    wr(9'h011, mk(4'h0, 4'hF, 9'h022, 9'h030));
    wr(9'h1FF, mk(4'hF, 4'h4, 9'h023, 9'h040));
    wr(9'h040, mk(4'h3, 4'h4, 9'h024, 9'h000));
    wr(9'h041, 32'h0000_0000);
    wr(9'h020, 32'hABCD_EFFF);
    wr(9'h021, 32'h1234_5678);
    wr(9'h022, 32'h0BAD_F00D);
    wr(9'h023, 32'hFFFF_FFFF);
    wr(9'h024, 32'h5555_5555);
    wr(9'h030, 32'hFFFF_F1FF);
    @(posedge mclk);
    ldWr <= 1'b0;
    run <= 1'b1;
    $display("t_load done");
  endtask : t_load

  task automatic t_jumps;
    step(0, 9'h010, 2'b01, 2'b11);
    step(4, 9'h011, 2'b01, 2'b00);
    step(4, 9'h1FF, 2'b01, 2'b10);
    step(4, 9'h040, 2'b10, 2'b11);
    @(posedge mclk);
    run <= 1'b0;
    step(0, 9'h041, 2'b10, 2'b00);
    repeat (8) @(posedge mclk);
    #1;
    chk(32'(pcOut), 32'h0000_0041);
    $display("t_jumps done");
  endtask : t_jumps

  task automatic t_ram;
    rd(9'h020, 32'hABCD_EE01);
    rd(9'h021, 32'h1234_5678);
    rd(9'h022, 32'h0BAD_F00D);
    rd(9'h023, 32'hFFFF_FE00);
    rd(9'h024, 32'h5555_5555);
    rd(9'h030, 32'hFFFF_F1FF);
    $display("t_ram done");
  endtask : t_ram

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #20000;
    errCount++;
    $display("Error at %0t: watchdog expired", $time);
    wrap_up();
  end

  initial begin
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    t_load();
    t_jumps();
    t_ram();
    wrap_up();
  end
endmodule : jlbu_core_tb
